// ### src/ric_pkg.sv
// Purpose: Shared constants, types and helpers of the reset and start-up loader.
// Assumes: One 250 MHz clock; shared memory is read one long word at a time.
// Notes:   Channel spec words keep the off and abort flags in their low bits.
package ric_pkg;
    localparam int          SLOT_N      = 32;
    localparam int          CLK_MHZ     = 250;
    localparam logic [7:0]  REG_STATUS  = 8'h00;
    localparam logic [7:0]  REG_ACTION  = 8'h04;
    localparam logic [7:0]  REG_CTRLADR = 8'h08;
    localparam logic [7:0]  REG_CSP     = 8'h0c;
    localparam logic [7:0]  REG_SEL     = 8'h10;
    localparam logic [7:0]  REG_TSWORD  = 8'h14;
    localparam logic [7:0]  REG_CHWORD  = 8'h18;
    localparam logic [7:0]  REG_GAP     = 8'h1c;
    localparam int          PCM_HI      = 31;
    localparam int          PCM_LO      = 29;
    localparam int          MFL_HI      = 28;
    localparam int          MFL_LO      = 16;
    localparam int          IN_BIT      = 15;
    localparam int          ICO_BIT     = 14;
    localparam int          CHN_HI      = 12;
    localparam int          CHN_LO      = 8;
    localparam int          RES_BIT     = 6;
    localparam int          LOC_BIT     = 5;
    localparam int          LOOP_BIT    = 4;
    localparam int          INNER_RETURN_PATH_BIT   = 3;
    localparam logic [31:0] OFS_TSA     = 32'h0000000c;
    localparam logic [31:0] OFS_CHS     = 32'h0000008c;
    localparam int          CHS_SHIFT   = 4;
    localparam logic [31:0] TS_WORD_RST = 32'h00000000;
    // Bit 0 rx_off_flag, bit 1 tx_off_flag, bit 2 rx_abort_flag, bit 3 tx_abort_flag.
    localparam logic [31:0] CH_WORD_RST = 32'h00000003;
    localparam logic [1:0]  SYNC_EDGES  = 2'h2;
    localparam logic [7:0]  GAP_RST     = 8'h00;
    localparam logic [2:0]  PCM_RST     = 3'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CSP  = 3'b001,
        ST_ACT  = 3'b010,
        ST_TS   = 3'b011,
        ST_CH   = 3'b100
    } ric_state_e;

    typedef struct packed {
        logic        rd;
        logic [31:0] addr;
    } ric_mem_s;

    typedef struct packed {
        ric_state_e              st;
        logic                    ar_prev;
        logic [4:0]              strap;
        logic [31:0]             ctrl_addr;
        logic [31:0]             csp;
        logic [31:0]             action;
        logic                    all_ch;
        logic [4:0]              idx;
        logic [SLOT_N-1:0][31:0] ts;
        logic [SLOT_N-1:0][31:0] ch;
        logic [1:0]              rx_edges;
        logic [1:0]              tx_edges;
        logic                    rx_prev;
        logic                    tx_prev;
        logic                    rx_sync;
        logic                    tx_sync;
        logic [4:0]              sel;
        logic [7:0]              gap;
        logic [2:0]              esx;
        logic                    rx_fill;
        logic                    dma_hold;
        ric_mem_s                mem;
        logic [31:0]             rdata;
        logic                    txd;
        logic                    txd_oe_n;
        logic                    rx_bit;
        logic                    rx_valid;
        logic                    done;
    } ric_state_s;

    function automatic logic [31:0] strap_addr(input logic [4:0] s);
        strap_addr = {{10{s[4]}}, {6{s[3]}}, {12{s[2]}}, s[1], s[0], 2'b00};
    endfunction : strap_addr

    function automatic logic [31:0] chan_addr(input logic [31:0] csp, input logic [4:0] n);
        chan_addr = csp + OFS_CHS + ({27'h0000000, n} << CHS_SHIFT);
    endfunction : chan_addr
endpackage : ric_pkg

// ### src/ric_loader.sv
// Purpose: Reset defaults, strap decoding, action driven initialization and frame resync.
// Assumes: All inputs synchronous to clk_sys; mem_ack answers a held mem_rd.
// Notes:   Only the first word of each channel spec is kept in channel_state_ram.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
// How it works
// - Reset initializes all logic, floats the output line, stops channel work.
// - After reset buffers empty, no tx_buffer_pool space, DMA held.
// - Reset sets rx/tx off flags and clears rx/tx abort flags everywhere.
// - Reset maps slots to channel zero, fill/mask zero, inversions cleared.
// - Reset clears loops and max_frame_length and selects highway format 000.
// - Reset sets gap_flag_count to zero.
// - Reset clears E, S, X bits and puts receivers in interframe_fill idle.
// - No memory access after reset until an action request arrives.
// - Initialization loads slot map and chosen channel specs into state RAM.
// - Each direction resyncs on the second rising edge of its sync pulse.
// - Before resync, received data is ignored and transmit line floats.
// - Every action service first reads the start pointer at the strap address.
// - Straps are sampled on the falling edge of action_request_n.
// - Straps fill address fields 31:22, 21:16, 15:4, bit 3, bit 2.
module ric_loader (
    input  wire logic           clk_sys,          // 250 MHz system clock
    input  wire logic           resetn,           // Asynchronous reset, active low
    input  wire logic           ce,               // Clock enable, freezes all state when low
    input  wire logic [4:0]     ctrl_base_straps, // Strap pins for the start pointer address
    input  wire logic           action_request_n, // Action request, falling edge starts service
    input  wire logic           tx_sync_pulse,    // Transmit frame sync
    input  wire logic           rx_sync_pulse,    // Receive frame sync
    input  wire logic           rxd,              // Serial receive data
    output logic                txd,              // Serial transmit data
    output logic                txd_oe_n,         // Transmit output enable, low drives
    output logic                rx_bit,           // Received bit passed on after resync
    output logic                rx_valid,         // Marks rx_bit as accepted
    output logic                dma_hold,         // DMA held for all link lists
    output logic                mem_rd,           // Shared memory read request
    output logic [31:0]         mem_addr,         // Shared memory long word address
    input  wire logic [31:0]    mem_rdata,        // Shared memory read data
    input  wire logic           mem_ack,          // Read data valid, ends mem_rd
    input  wire logic [7:0]     reg_addr,         // Register byte address
    input  wire logic [31:0]    reg_wdata,        // Register write data
    input  wire logic           reg_wr,           // Register write strobe
    input  wire logic           reg_rd,           // Register read strobe
    output logic [31:0]         reg_rdata,        // Read data, one cycle after reg_rd
    output logic                init_done         // One pulse when a service ends
);
    ric_pkg::ric_state_s q;
    ric_pkg::ric_state_s d;
    logic                ar_fall;
    logic [31:0]         rd_val;

    assign ar_fall = q.ar_prev && !action_request_n;

    always_comb begin
        d = q;
        d.done = 1'b0;
        d.ar_prev = action_request_n;
        // Frame resync: count rising sync edges, the second one aligns slot 0.
        d.rx_prev = rx_sync_pulse;
        d.tx_prev = tx_sync_pulse;
        if (rx_sync_pulse && !q.rx_prev && !q.rx_sync) begin
            d.rx_edges = q.rx_edges + 2'h1;
            if (q.rx_edges + 2'h1 == ric_pkg::SYNC_EDGES) begin
                d.rx_sync = 1'b1;
            end
        end
        if (tx_sync_pulse && !q.tx_prev && !q.tx_sync) begin
            d.tx_edges = q.tx_edges + 2'h1;
            if (q.tx_edges + 2'h1 == ric_pkg::SYNC_EDGES) begin
                d.tx_sync = 1'b1;
            end
        end
        // Until resync the line floats and incoming bits are dropped.
        d.txd_oe_n = !q.tx_sync;
        d.txd      = 1'b1;
        d.rx_bit   = q.rx_sync ? rxd : 1'b1;
        d.rx_valid = q.rx_sync;
        d.mem.rd   = 1'b0;
        case (q.st)
            ric_pkg::ST_IDLE: begin
                // Straps are taken only here, so a pointer fetch never sees them move.
                if (ar_fall) begin
                    d.strap     = ctrl_base_straps;
                    d.ctrl_addr = ric_pkg::strap_addr(ctrl_base_straps);
                    d.st        = ric_pkg::ST_CSP;
                end
            end
            ric_pkg::ST_CSP: begin
                d.mem.rd   = !mem_ack;
                d.mem.addr = q.ctrl_addr;
                if (mem_ack && q.mem.rd) begin
                    d.csp      = mem_rdata;
                    d.mem.addr = mem_rdata;
                    d.mem.rd   = 1'b1;
                    d.st       = ric_pkg::ST_ACT;
                end
            end
            ric_pkg::ST_ACT: begin
                d.mem.rd = !mem_ack;
                if (mem_ack && q.mem.rd) begin
                    d.mem.rd = 1'b0;
                    d.action = mem_rdata;
                    d.idx    = 5'h00;
                    d.all_ch = mem_rdata[ric_pkg::RES_BIT];
                    if (mem_rdata[ric_pkg::RES_BIT] || mem_rdata[ric_pkg::IN_BIT]) begin
                        d.mem.rd   = 1'b1;
                        d.mem.addr = q.csp + ric_pkg::OFS_TSA;
                        d.st       = ric_pkg::ST_TS;
                    end else if (mem_rdata[ric_pkg::ICO_BIT]) begin
                        // The word must land in the selected channel's entry, not entry 0.
                        d.idx      = mem_rdata[ric_pkg::CHN_HI:ric_pkg::CHN_LO];
                        d.mem.rd   = 1'b1;
                        d.mem.addr = ric_pkg::chan_addr(q.csp,
                                         mem_rdata[ric_pkg::CHN_HI:ric_pkg::CHN_LO]);
                        d.st       = ric_pkg::ST_CH;
                    end else begin
                        d.done = 1'b1;
                        d.st   = ric_pkg::ST_IDLE;
                    end
                end
            end
            ric_pkg::ST_TS: begin
                d.mem.rd = !mem_ack;
                if (mem_ack && q.mem.rd) begin
                    d.ts[q.idx] = mem_rdata;
                    d.mem.rd    = 1'b1;
                    d.idx       = q.idx + 5'h01;
                    if (q.idx == 5'h1f) begin
                        d.idx      = q.all_ch ? 5'h00 : q.action[ric_pkg::CHN_HI:ric_pkg::CHN_LO];
                        d.mem.addr = ric_pkg::chan_addr(q.csp, d.idx);
                        d.st       = ric_pkg::ST_CH;
                    end else begin
                        d.mem.addr = q.mem.addr + 32'h00000004;
                    end
                end
            end
            ric_pkg::ST_CH: begin
                d.mem.rd = !mem_ack;
                if (mem_ack && q.mem.rd) begin
                    d.ch[q.idx] = mem_rdata;
                    if (q.all_ch && q.idx != 5'h1f) begin
                        d.idx      = q.idx + 5'h01;
                        d.mem.rd   = 1'b1;
                        d.mem.addr = ric_pkg::chan_addr(q.csp, q.idx + 5'h01);
                    end else begin
                        d.mem.rd = 1'b0;
                        d.done   = 1'b1;
                        d.st     = ric_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                d.st = ric_pkg::ST_IDLE;
            end
        endcase
        // Register port: reads answer in the next cycle only, unmapped reads give zero.
        rd_val = 32'h00000000;
        case (reg_addr)
            ric_pkg::REG_STATUS:  rd_val = {22'h000000, q.esx, q.rx_fill, q.dma_hold,
                                            q.st != ric_pkg::ST_IDLE, q.tx_sync, q.rx_sync,
                                            q.tx_edges};
            ric_pkg::REG_ACTION:  rd_val = q.action;
            ric_pkg::REG_CTRLADR: rd_val = q.ctrl_addr;
            ric_pkg::REG_CSP:     rd_val = q.csp;
            ric_pkg::REG_SEL:     rd_val = {27'h0000000, q.sel};
            ric_pkg::REG_TSWORD:  rd_val = q.ts[q.sel];
            ric_pkg::REG_CHWORD:  rd_val = q.ch[q.sel];
            ric_pkg::REG_GAP:     rd_val = {24'h000000, q.gap};
            default:              rd_val = 32'h00000000;
        endcase
        d.rdata = reg_rd ? rd_val : 32'h00000000;
        if (reg_wr && reg_addr == ric_pkg::REG_SEL) begin
            d.sel = reg_wdata[4:0];
        end
        if (reg_wr && reg_addr == ric_pkg::REG_GAP) begin
            d.gap = reg_wdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            q          <= '0;
            q.st       <= ric_pkg::ST_IDLE;
            q.ar_prev  <= 1'b1;
            q.txd      <= 1'b1;
            q.txd_oe_n <= 1'b1;
            q.rx_bit   <= 1'b1;
            q.dma_hold <= 1'b1;
            q.rx_fill  <= 1'b1;
            q.esx      <= 3'h0;
            q.gap      <= ric_pkg::GAP_RST;
            q.action   <= {ric_pkg::PCM_RST, 29'h00000000};
            for (int i = 0; i < ric_pkg::SLOT_N; i++) begin
                q.ts[i] <= ric_pkg::TS_WORD_RST;
                q.ch[i] <= ric_pkg::CH_WORD_RST;
            end
        end else if (ce) begin
            q <= d;
        end
    end

    assign txd       = q.txd;
    assign txd_oe_n  = q.txd_oe_n;
    assign rx_bit    = q.rx_bit;
    assign rx_valid  = q.rx_valid;
    assign dma_hold  = q.dma_hold;
    assign mem_rd    = q.mem.rd;
    assign mem_addr  = q.mem.addr;
    assign reg_rdata = q.rdata;
    assign init_done = q.done;

    // Checks that tie outputs to their causes.
    property p_tx_float;
        @(posedge clk_sys) disable iff (!resetn)
        !q.tx_sync |=> (txd_oe_n || q.tx_sync);
    endproperty
    a_tx_float: assert property (p_tx_float) else $error("txd driven before resync");

    property p_rx_ignore;
        @(posedge clk_sys) disable iff (!resetn)
        rx_valid |-> $past(q.rx_sync);
    endproperty
    a_rx_ignore: assert property (p_rx_ignore) else $error("rx data before resync");

    property p_idle_quiet;
        @(posedge clk_sys) disable iff (!resetn)
        (q.st == ric_pkg::ST_IDLE) |-> !mem_rd;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("memory read while idle");

    property p_csp_addr;
        @(posedge clk_sys) disable iff (!resetn)
        (q.st == ric_pkg::ST_CSP && mem_rd) |-> mem_addr == ric_pkg::strap_addr(q.strap);
    endproperty
    a_csp_addr: assert property (p_csp_addr) else $error("pointer read at wrong address");

    property p_strap_take;
        @(posedge clk_sys) disable iff (!resetn)
        (ce && ar_fall && q.st == ric_pkg::ST_IDLE) |=>
            q.strap == $past(ctrl_base_straps) && q.st == ric_pkg::ST_CSP;
    endproperty
    a_strap_take: assert property (p_strap_take) else $error("straps not taken");

    property p_strap_field;
        @(posedge clk_sys) disable iff (!resetn)
        (q.st == ric_pkg::ST_CSP) |-> q.ctrl_addr[31:22] == {10{q.strap[4]}} &&
            q.ctrl_addr[15:4] == {12{q.strap[2]}} && q.ctrl_addr[1:0] == 2'h0;
    endproperty
    a_strap_field: assert property (p_strap_field) else $error("strap address fields");

    property p_second_edge;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(q.rx_sync) |-> $past(q.rx_edges) == 2'h1 && $past(rx_sync_pulse);
    endproperty
    a_second_edge: assert property (p_second_edge) else $error("rx resync not on edge 2");

    property p_ch_only;
        @(posedge clk_sys) disable iff (!resetn)
        (q.st == ric_pkg::ST_CH && !q.all_ch && mem_rd) |-> mem_addr ==
            ric_pkg::chan_addr(q.csp, q.action[ric_pkg::CHN_HI:ric_pkg::CHN_LO]);
    endproperty
    a_ch_only: assert property (p_ch_only) else $error("wrong channel spec fetched");

    property p_act_after_csp;
        @(posedge clk_sys) disable iff (!resetn)
        (q.st == ric_pkg::ST_ACT && mem_rd) |-> mem_addr == q.csp;
    endproperty
    a_act_after_csp: assert property (p_act_after_csp) else $error("action read misplaced");

    property p_tx_second;
        @(posedge clk_sys) disable iff (!resetn)
        $rose(q.tx_sync) |-> $past(q.tx_edges) == 2'h1 && $past(tx_sync_pulse);
    endproperty
    a_tx_second: assert property (p_tx_second) else $error("tx resync not on edge 2");

    property p_rx_drop;
        @(posedge clk_sys) disable iff (!resetn)
        !rx_valid |-> rx_bit;
    endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("rx bit leaked");

    property p_dma_hold;
        @(posedge clk_sys) disable iff (!resetn)
        dma_hold;
    endproperty
    a_dma_hold: assert property (p_dma_hold) else $error("dma released");

    property p_done_idle;
        @(posedge clk_sys) disable iff (!resetn)
        init_done |-> q.st == ric_pkg::ST_IDLE && !mem_rd;
    endproperty
    a_done_idle: assert property (p_done_idle) else $error("service ended open");

    // Straps may move during a service; the latched copy must not follow them.
    property p_strap_hold;
        @(posedge clk_sys) disable iff (!resetn)
        (ce && q.st != ric_pkg::ST_IDLE) |=> $stable(q.strap);
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("straps resampled");

    property p_ts_walk;
        @(posedge clk_sys) disable iff (!resetn)
        (q.st == ric_pkg::ST_TS && mem_rd) |->
            mem_addr == q.csp + ric_pkg::OFS_TSA + {25'h0000000, q.idx, 2'b00};
    endproperty
    a_ts_walk: assert property (p_ts_walk) else $error("slot word misplaced");

    property p_ico_slot;
        @(posedge clk_sys) disable iff (!resetn)
        (ce && q.st == ric_pkg::ST_ACT && mem_ack && q.mem.rd &&
            mem_rdata[ric_pkg::ICO_BIT] && !mem_rdata[ric_pkg::RES_BIT] &&
            !mem_rdata[ric_pkg::IN_BIT]) |=>
            q.idx == $past(mem_rdata[ric_pkg::CHN_HI:ric_pkg::CHN_LO]);
    endproperty
    a_ico_slot: assert property (p_ico_slot) else $error("wrong channel slot");

    c_res:  cover property (@(posedge clk_sys) disable iff (!resetn)
        init_done && q.all_ch);
    c_ico:  cover property (@(posedge clk_sys) disable iff (!resetn)
        init_done && q.action[ric_pkg::ICO_BIT]);
    c_sync: cover property (@(posedge clk_sys) disable iff (!resetn)
        q.rx_sync && q.tx_sync);
    c_in:   cover property (@(posedge clk_sys) disable iff (!resetn)
        init_done && q.action[ric_pkg::IN_BIT]);
    c_move: cover property (@(posedge clk_sys) disable iff (!resetn)
        q.st == ric_pkg::ST_CSP && ctrl_base_straps != q.strap);
endmodule : ric_loader

// ### sim/ric_mem_model.sv
// Purpose: Shared memory seen by the loader, answering long word reads.
// Assumes: One read is served at a time; dly sets the wait before each answer.
// Notes:   Words beyond the pointer and action word carry their own address.
`timescale 1ns/1ps
module ric_mem_model (
    input  wire logic        clk_sys,    // System clock
    input  wire logic        resetn,     // Asynchronous reset, active low
    input  wire logic        clr,        // Clears the read log
    input  wire logic        mem_rd,     // Read request from the loader
    input  wire logic [31:0] mem_addr,   // Read address
    input  wire logic [31:0] ptr,        // Start pointer stored at the strap address
    input  wire logic [31:0] action,     // Action word stored at the pointer
    input  wire logic [3:0]  dly,        // Wait cycles before each answer
    output logic      [31:0] mem_rdata,  // Read data
    output logic             mem_ack,    // One cycle answer pulse
    output logic      [7:0]  n_reads,    // Reads served since clr
    output logic      [31:0] first_addr  // Address of the first read since clr
);
    logic [3:0] cnt_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mem_ack    <= 1'b0;
            mem_rdata  <= 32'h00000000;
            cnt_q      <= 4'h0;
            n_reads    <= 8'h00;
            first_addr <= 32'h00000000;
        end else begin
            mem_ack <= 1'b0;
            if (clr) begin
                n_reads <= 8'h00;
            end
            if (mem_ack) begin
                // A released data bus must not keep showing the word just read.
                mem_rdata <= ~mem_rdata;
            end else if (mem_rd && cnt_q == dly) begin
                mem_ack <= 1'b1;
                cnt_q   <= 4'h0;
                n_reads <= n_reads + 8'h01;
                if (n_reads == 8'h00) begin
                    first_addr <= mem_addr;
                end
                // Lists are laid out before any action; low bits keep both off flags set.
                mem_rdata <= (n_reads == 8'h00) ? ptr : (n_reads == 8'h01) ? action
                           : {mem_addr[15:0], 16'ha5c3};
            end else if (mem_rd) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end
    end
endmodule : ric_mem_model

// ### sim/reset_init_ctrl_addr_decode_tb_top.sv
// Purpose: Self-checking bench for the reset and start-up loader.
// Assumes: Register reads answer one cycle after the strobe.
// Notes:   The start pointer is fixed; strap address and actions vary per test.
`timescale 1ns/1ps
module reset_init_ctrl_addr_decode_tb_top;
    localparam logic [31:0] PTR = 32'h00120000;
    logic clk_sys, resetn, ce, req_n, tsync, rsync, rxd, txd, txd_oe_n, rx_bit, rx_valid;
    logic dma_hold, mem_rd, mem_ack, reg_wr, reg_rd, init_done, m_clr;
    logic [4:0]  straps;
    logic [7:0]  reg_addr, n_reads;
    logic [3:0]  m_dly;
    logic [31:0] mem_addr, mem_rdata, reg_wdata, reg_rdata, m_act, first_addr;
    int          mismatches, total_checks;

    ric_loader u_dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
        .ctrl_base_straps(straps), .action_request_n(req_n), .tx_sync_pulse(tsync),
        .rx_sync_pulse(rsync), .rxd(rxd), .txd(txd), .txd_oe_n(txd_oe_n), .rx_bit(rx_bit),
        .rx_valid(rx_valid), .dma_hold(dma_hold), .mem_rd(mem_rd), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .init_done(init_done));
    ric_mem_model u_mem (.clk_sys(clk_sys), .resetn(resetn), .clr(m_clr), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .ptr(PTR), .action(m_act), .dly(m_dly), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack), .n_reads(n_reads), .first_addr(first_addr));

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] pat(input logic [31:0] a);
        pat = {a[15:0], 16'ha5c3};
    endfunction : pat

    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk_w

    task automatic chk_b(input logic got, input logic exp, input string m);
        chk_w({31'h00000000, got}, {31'h00000000, exp}, m);
    endtask : chk_b

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string m);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 chk_w(reg_rdata, exp, m);
        @(posedge clk_sys);
    endtask : rd_chk

    task automatic words(input logic [4:0] s, input logic [31:0] ts, input logic [31:0] ch);
        wr(ric_pkg::REG_SEL, {27'h0000000, s});
        rd_chk(ric_pkg::REG_TSWORD, ts, "slot word");
        rd_chk(ric_pkg::REG_CHWORD, ch, "channel word");
    endtask : words

    task automatic service(input logic [4:0] s, input logic [31:0] exp_a,
                           input logic [31:0] act, input logic [3:0] dl, input logic [7:0] nr);
        int i;
        straps <= s;
        m_act  <= act;
        m_dly  <= dl;
        m_clr  <= 1'b1;
        @(posedge clk_sys);
        m_clr <= 1'b0;
        req_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        straps <= ~s;
        i = 0;
        do begin
            @(posedge clk_sys);
            #1 i++;
        end while (init_done !== 1'b1 && i < 600);
        req_n <= 1'b1;
        chk_b(init_done, 1'b1, "service end");
        chk_w({24'h000000, n_reads}, {24'h000000, nr}, "read count");
        chk_w(first_addr, exp_a, "first read address");
        rd_chk(ric_pkg::REG_CTRLADR, exp_a, "strap address");
        rd_chk(ric_pkg::REG_CSP, PTR, "start pointer");
        rd_chk(ric_pkg::REG_ACTION, act, "action word");
    endtask : service

    task automatic t_reset;
        chk_b(txd_oe_n, 1'b1, "tx float");
        chk_b(dma_hold, 1'b1, "dma hold");
        chk_b(rx_valid, 1'b0, "rx idle");
        rd_chk(ric_pkg::REG_ACTION, 32'h00000000, "action default");
        rd_chk(ric_pkg::REG_GAP, 32'h00000000, "gap default");
        rd_chk(ric_pkg::REG_STATUS, 32'h00000060, "status default");
        words(5'h00, 32'h00000000, 32'h00000003);
        words(5'h1f, 32'h00000000, 32'h00000003);
        repeat (30) begin
            @(posedge clk_sys);
            #1 chk_b(mem_rd, 1'b0, "no access before request");
        end
        $display("test reset done");
    endtask : t_reset

    task automatic t_regs;
        wr(ric_pkg::REG_GAP, 32'h0000005c);
        wr(ric_pkg::REG_ACTION, 32'hffffffff);
        wr(8'h40, 32'h12345678);
        rd_chk(ric_pkg::REG_GAP, 32'h0000005c, "gap write");
        rd_chk(ric_pkg::REG_ACTION, 32'h00000000, "read-only action");
        rd_chk(8'h40, 32'h00000000, "unmapped read");
        ce <= 1'b0;
        wr(ric_pkg::REG_GAP, 32'h00000033);
        ce <= 1'b1;
        rd_chk(ric_pkg::REG_GAP, 32'h0000005c, "frozen write");
        wr(ric_pkg::REG_GAP, 32'h00000000);
        $display("test registers done");
    endtask : t_regs

    task automatic t_straps;
        logic [4:0]  sv [4];
        logic [31:0] av [4];
        sv = '{5'b10101, 5'b01010, 5'b11111, 5'b00001};
        av = '{32'hffc0fff4, 32'h003f0008, 32'hfffffffc, 32'h00000004};
        for (int k = 0; k < 4; k++) begin
            service(sv[k], av[k], 32'h00000000, 4'(k), 8'h02);
        end
        $display("test straps done");
    endtask : t_straps

    task automatic t_init;
        service(5'h00, 32'h00000000, 32'h00004500, 4'h3, 8'h03);
        words(5'h05, 32'h00000000, pat(PTR + 32'h8c + 32'h50));
        service(5'h00, 32'h00000000, 32'h00008900, 4'h0, 8'h23);
        words(5'h09, pat(PTR + 32'h30), pat(PTR + 32'h8c + 32'h90));
        service(5'h00, 32'h00000000, 32'h00000040, 4'h1, 8'h42);
        words(5'h07, pat(PTR + 32'h28), pat(PTR + 32'h8c + 32'h70));
        words(5'h1f, pat(PTR + 32'h88), pat(PTR + 32'h8c + 32'h1f0));
        $display("test init done");
    endtask : t_init

    task automatic sp(input logic tx);
        if (tx) tsync <= 1'b1;
        else rsync <= 1'b1;
        repeat (2) @(posedge clk_sys);
        tsync <= 1'b0;
        rsync <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
    endtask : sp

    task automatic t_sync;
        rxd <= 1'b0;
        sp(1'b0);
        chk_b(rx_valid, 1'b0, "rx after one edge");
        chk_b(rx_bit, 1'b1, "rx data ignored");
        sp(1'b0);
        chk_b(rx_valid, 1'b1, "rx after two edges");
        chk_b(rx_bit, 1'b0, "rx data passed");
        chk_b(txd_oe_n, 1'b1, "tx still floating");
        sp(1'b1);
        chk_b(txd_oe_n, 1'b1, "tx after one edge");
        sp(1'b1);
        chk_b(txd_oe_n, 1'b0, "tx after two edges");
        chk_b(txd, 1'b1, "tx line idles high");
        $display("test sync done");
    endtask : t_sync

    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out

    initial begin
        {resetn, req_n, tsync, rsync, rxd, ce, reg_wr, reg_rd, m_clr} = 9'b010011000;
        {straps, reg_addr, reg_wdata, m_act, m_dly} = '0;
        mismatches   = 0;
        total_checks = 0;
        repeat (5) @(posedge clk_sys);
        #1 chk_b(txd_oe_n, 1'b1, "tx float in reset");
        chk_b(mem_rd, 1'b0, "no read in reset");
        @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        #1;
        // The first sync edge comes long after reset release.
        t_reset;
        t_regs;
        t_straps;
        t_init;
        t_sync;
        close_out;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        close_out;
    end
endmodule : reset_init_ctrl_addr_decode_tb_top
